// ---- src/debug_config_status_reg.sv ----
// Debug configuration and status register with its serial link
`timescale 1ns/1ns
module debug_config_status_reg
  import dbg_pkg::*;
(
  input  wire logic        clk,
  input  wire logic        rst_n,
  // Serial link
  input  wire logic        debug_serial_clock,
  input  wire logic        link_rst_n,
  input  wire logic        debug_serial_in,
  output logic             debug_serial_out,
  // Supervisor write port
  input  wire logic        sup_wr,
  input  wire logic [31:0] sup_wdata,
  input  wire logic        tdr_wr,
  input  wire logic [3:0]  bp_state_in,
  input  wire logic        bp_state_upd,
  // Halt causes and restart
  input  wire logic        fault_halt,
  input  wire logic        trigger_halt,
  input  wire logic        halt_insn,
  input  wire logic        breakpoint_request_input,
  input  wire logic        core_restart,
  // Core reset and events
  input  wire logic        reset_input,
  input  wire logic        trace_exc,
  input  wire logic        in_emulator,
  input  wire logic        is_code_ref,
  input  wire logic        user_mode,
  input  wire logic        insn_retire,
  input  wire logic        go_cmd,
  input  wire logic [2:0]  core_irq_priority_level,
  // Operand and branch capture
  input  wire logic        op_valid,
  input  wire logic        op_write,
  input  wire logic [1:0]  op_size,
  input  wire logic [31:0] op_data,
  input  wire logic        br_taken,
  input  wire logic        br_variable,
  input  wire logic [31:0] br_target,
  // Outputs to core
  output logic [3:0]       debug_data_port,
  output logic [1:0]       transfer_type,
  output logic [2:0]       transfer_modifier,
  output logic             enter_emulation,
  output logic             halt_allowed,
  output logic             nonpipelined_exec,
  output logic             step_halt,
  output logic [2:0]       irq_level_eff,
  output logic [31:0]      csr_q
);
  // ----------------------------------------
  // Internal signals
  // ----------------------------------------
  ser_if sif ();

  logic [3:0]  status_q;
  logic [3:0]  flag_q;
  logic [3:0]  flag_set;
  logic [3:0]  flag_clr;
  logic [31:0] cfg_q;
  logic        rst_s1_q, rst_s2_q, rst_prev_q;
  logic        emu_q;
  logic        rx_s1_q, rx_s2_q, rx_s3_q;
  logic        tx_tgl_q;
  logic [31:0] tx_word_q;
  logic        link_wr, link_rd;
  logic        cfg_wr;
  logic [31:0] cfg_wdata;
  logic [31:0] csr_view;
  logic [35:0] cap_q;
  logic [3:0]  cap_n_q;
  logic        stepping_q;

  // ----------------------------------------
  // Serial link shifter
  // ----------------------------------------
  dbg_serial_link u_link (
    .debug_serial_clock (debug_serial_clock),
    .frame_rst_n        (link_rst_n),
    .debug_serial_in    (debug_serial_in),
    .debug_serial_out   (debug_serial_out),
    .sif                (sif.link)
  );

  // ----------------------------------------
  // Link command crossing
  // ----------------------------------------
  always_ff @(posedge clk) begin
    if (!rst_n) begin
      rx_s1_q <= 1'b0;
      rx_s2_q <= 1'b0;
      rx_s3_q <= 1'b0;
    end else begin
      rx_s1_q <= sif.rx_tgl;
      rx_s2_q <= rx_s1_q;
      rx_s3_q <= rx_s2_q;
    end
  end

  function automatic logic cmd_is(input logic [35:0] word, input logic [3:0] cmd);
    cmd_is = (word[35:32] == cmd);
  endfunction : cmd_is

  assign link_wr = (rx_s2_q != rx_s3_q) && cmd_is(sif.rx_word, CMD_WR_CSR);
  assign link_rd = (rx_s2_q != rx_s3_q) && cmd_is(sif.rx_word, CMD_RD_CSR);

  // ----------------------------------------
  // Configuration bits
  // ----------------------------------------
  always_comb begin
    cfg_wr    = link_wr || (sup_wr && !cfg_q[IPW_BIT]);
    cfg_wdata = link_wr ? sif.rx_word[31:0] : sup_wdata;
    if (!link_wr) begin
      cfg_wdata[IPW_BIT] = cfg_q[IPW_BIT];
    end
  end

  always_ff @(posedge clk) begin
    if (!rst_n) begin
      cfg_q <= CSR_RESET;
    end else if (cfg_wr) begin
      cfg_q <= (cfg_wdata & CFG_WMASK) | (cfg_wdata & (32'h1 << IPW_BIT));
    end
  end

  // ----------------------------------------
  // Breakpoint status
  // ----------------------------------------
  always_ff @(posedge clk) begin
    if (!rst_n) begin
      status_q <= BP_NONE;
    end else if (tdr_wr) begin
      status_q <= BP_NONE;
    end else if (bp_state_upd) begin
      status_q <= bp_state_in;
    end
  end

  // ----------------------------------------
  // Sticky halt-cause flags, set wins
  // ----------------------------------------
  assign flag_set[3] = fault_halt;
  assign flag_set[2] = trigger_halt;
  assign flag_set[1] = halt_insn;
  assign flag_set[0] = breakpoint_request_input;

  assign flag_clr[3] = link_rd;
  assign flag_clr[2] = link_rd || core_restart;
  assign flag_clr[1] = link_rd || core_restart;
  assign flag_clr[0] = link_rd || core_restart;

  generate
    for (genvar i = 0; i < 4; i++) begin : g_flag
      always_ff @(posedge clk) begin
        if (!rst_n) begin
          flag_q[i] <= 1'b0;
        end else begin
          flag_q[i] <= flag_set[i] || (flag_q[i] && !flag_clr[i]);
        end
      end
    end
  endgenerate

  // ----------------------------------------
  // Register view
  // ----------------------------------------
  always_comb begin
    csr_view = cfg_q;
    csr_view[STAT_LSB +: 4] = status_q;
    csr_view[FOF_BIT]  = flag_q[3];
    csr_view[TRG_BIT]  = flag_q[2];
    csr_view[HALT_BIT] = flag_q[1];
    csr_view[BRK_BIT]  = flag_q[0];
  end
  assign csr_q = csr_view;

  // ----------------------------------------
  // Read answer, values taken before clearing
  // ----------------------------------------
  always_ff @(posedge clk) begin
    if (!rst_n) begin
      tx_tgl_q  <= 1'b0;
      tx_word_q <= 32'h0;
    end else if (link_rd) begin
      tx_tgl_q  <= ~tx_tgl_q;
      tx_word_q <= csr_view;
    end
  end
  assign sif.tx_word = tx_word_q;
  assign sif.tx_tgl  = tx_tgl_q;

  // ----------------------------------------
  // Force emulation at reset release
  // ----------------------------------------
  always_ff @(posedge clk) begin
    if (!rst_n) begin
      rst_s1_q   <= 1'b0;
      rst_s2_q   <= 1'b0;
      rst_prev_q <= 1'b0;
      emu_q      <= 1'b0;
    end else begin
      rst_s1_q   <= reset_input;
      rst_s2_q   <= rst_s1_q;
      rst_prev_q <= rst_s2_q;
      if (rst_s2_q && !rst_prev_q) begin
        emu_q <= cfg_q[EMU_BIT];
      end else begin
        emu_q <= 1'b0;
      end
    end
  end

  assign enter_emulation = emu_q || (trace_exc && cfg_q[TRC_BIT]);

  // ----------------------------------------
  // Emulator address mapping
  // ----------------------------------------
  always_comb begin
    if (in_emulator && cfg_q[MAP_BIT]) begin
      transfer_type     = TT_EMU;
      transfer_modifier = is_code_ref ? TM_EMU_CODE : TM_EMU_DATA;
    end else if (in_emulator) begin
      transfer_type     = TT_NORM;
      transfer_modifier = is_code_ref ? TM_SUP_CODE : TM_SUP_DATA;
    end else begin
      transfer_type     = TT_NORM;
      transfer_modifier = 3'h0;
    end
  end

  // ----------------------------------------
  // Halt, pipeline and interrupt controls
  // ----------------------------------------
  assign halt_allowed      = !user_mode || cfg_q[UHE_BIT];
  assign nonpipelined_exec = cfg_q[NPL_BIT];
  assign irq_level_eff     = (cfg_q[SSM_BIT] && cfg_q[IPI_BIT]) ? 3'h0
                             : core_irq_priority_level;

  // ----------------------------------------
  // Single step, halt after each retired instruction
  // ----------------------------------------
  always_ff @(posedge clk) begin
    if (!rst_n) begin
      stepping_q <= 1'b0;
    end else if (!cfg_q[SSM_BIT]) begin
      stepping_q <= 1'b0;
    end else if (insn_retire) begin
      stepping_q <= 1'b1;
    end else if (go_cmd) begin
      stepping_q <= 1'b0;
    end
  end
  assign step_halt = stepping_q;

  // ----------------------------------------
  // Debug data capture, nibble per cycle
  // ----------------------------------------
  function automatic logic [3:0] op_nibbles(input logic [1:0] sz);
    case (sz)
      SZ_BYTE: op_nibbles = 4'd2;
      SZ_WORD: op_nibbles = 4'd4;
      default: op_nibbles = 4'd8;
    endcase
  endfunction : op_nibbles

  function automatic logic [3:0] br_nibbles(input logic [1:0] branch_target_byte_count);
    case (branch_target_byte_count)
      2'h1:    br_nibbles = 4'd4;
      2'h2:    br_nibbles = 4'd6;
      2'h3:    br_nibbles = 4'd8;
      default: br_nibbles = 4'd0;
    endcase
  endfunction : br_nibbles

  // ----------------------------------------
  // Capture selection
  // ----------------------------------------
  logic op_take;
  logic br_take;
  always_comb begin
    case (cfg_q[DDC_LSB +: 2])
      DDC_WR:  op_take = op_valid && op_write;
      DDC_RD:  op_take = op_valid && !op_write;
      DDC_RW:  op_take = op_valid;
      default: op_take = 1'b0;
    endcase
    br_take = br_taken && br_variable && (cfg_q[BTB_LSB +: 2] != 2'h0);
  end

  // ----------------------------------------
  // Capture shifter
  // ----------------------------------------
  always_ff @(posedge clk) begin
    if (!rst_n) begin
      cap_q   <= 36'h0;
      cap_n_q <= 4'd0;
    end else if (cap_n_q != 4'd0) begin
      cap_q   <= {4'h0, cap_q[35:4]};
      cap_n_q <= cap_n_q - 4'd1;
    end else if (br_take) begin
      cap_q   <= {4'h0, br_target};
      cap_n_q <= br_nibbles(cfg_q[BTB_LSB +: 2]);
    end else if (op_take) begin
      cap_q   <= {4'h0, op_data};
      cap_n_q <= op_nibbles(op_size);
    end
  end

  // ----------------------------------------
  // Debug data port output
  // ----------------------------------------
  always_ff @(posedge clk) begin
    if (!rst_n) begin
      debug_data_port <= 4'h0;
    end else if (cap_n_q != 4'd0) begin
      debug_data_port <= cap_q[3:0];
    end else begin
      debug_data_port <= {status_q[3:1], 1'b0};
    end
  end
endmodule : debug_config_status_reg

// ---- src/dbg_pkg.sv ----
// Constants for the debug configuration and status block
package dbg_pkg;
  // Register field positions
  localparam int STAT_LSB    = 28;
  localparam int FOF_BIT     = 27;
  localparam int TRG_BIT     = 26;
  localparam int HALT_BIT    = 25;
  localparam int BRK_BIT     = 24;
  localparam int IPW_BIT     = 16;
  localparam int MAP_BIT     = 15;
  localparam int TRC_BIT     = 14;
  localparam int EMU_BIT     = 13;
  localparam int DDC_LSB     = 11;
  localparam int UHE_BIT     = 10;
  localparam int BTB_LSB     = 8;
  localparam int NPL_BIT     = 6;
  localparam int IPI_BIT     = 5;
  localparam int SSM_BIT     = 4;
  // Writable bits of the register, apart from IPW_BIT which only the link writes
  localparam logic [31:0] CFG_WMASK  = 32'h0000ff70;
  localparam logic [31:0] CSR_RESET  = 32'h00000000;
  // Breakpoint states
  localparam logic [3:0] BP_NONE     = 4'h0;
  localparam logic [3:0] BP_WAIT1    = 4'h2;
  localparam logic [3:0] BP_TRIG1    = 4'h4;
  localparam logic [3:0] BP_WAIT2    = 4'ha;
  localparam logic [3:0] BP_TRIG2    = 4'hc;
  // Emulator mapping codes
  localparam logic [1:0] TT_EMU      = 2'h2;
  localparam logic [1:0] TT_NORM     = 2'h0;
  localparam logic [2:0] TM_EMU_DATA = 3'h5;
  localparam logic [2:0] TM_EMU_CODE = 3'h6;
  localparam logic [2:0] TM_SUP_DATA = 3'h5;
  localparam logic [2:0] TM_SUP_CODE = 3'h6;
  // Operand capture selects
  localparam logic [1:0] DDC_NONE    = 2'h0;
  localparam logic [1:0] DDC_WR      = 2'h1;
  localparam logic [1:0] DDC_RD      = 2'h2;
  localparam logic [1:0] DDC_RW      = 2'h3;
  // Access sizes
  localparam logic [1:0] SZ_BYTE     = 2'h1;
  localparam logic [1:0] SZ_WORD     = 2'h2;
  localparam logic [1:0] SZ_LONG     = 2'h0;
  // Serial link
  localparam int SER_BITS = 32;
  localparam logic [5:0] SER_CNT_MAX = 6'd32;
  // Serial link commands
  localparam logic [3:0] CMD_RD_CSR  = 4'h1;
  localparam logic [3:0] CMD_WR_CSR  = 4'h2;
  localparam logic [3:0] CMD_GO      = 4'h3;
endpackage : dbg_pkg

// ---- src/ser_if.sv ----
// Word transfer between the serial link domain and the core domain
`timescale 1ns/1ns
interface ser_if;
  logic [35:0] rx_word;
  logic        rx_tgl;
  logic [31:0] tx_word;
  logic        tx_tgl;
  modport link (output rx_word, output rx_tgl, input tx_word, input tx_tgl);
  modport core (input rx_word, input rx_tgl, output tx_word, output tx_tgl);
endinterface : ser_if

// ---- src/dbg_serial_link.sv ----
// Serial link shifter running on the debug serial clock
`timescale 1ns/1ns
module dbg_serial_link
  import dbg_pkg::*;
(
  input  wire logic   debug_serial_clock,
  input  wire logic   frame_rst_n,
  input  wire logic   debug_serial_in,
  output logic        debug_serial_out,
  ser_if.link         sif
);
  logic [35:0] rx_sh_q;
  logic [5:0]  cnt_q;
  logic [31:0] tx_sh_q;
  logic        tx_s1_q;
  logic        tx_s2_q;
  logic        tx_seen_q;
  logic        rx_tgl_q;
  logic [35:0] rx_word_q;

  // ----------------------------------------
  // Receive and transmit shifters
  // ----------------------------------------
  always_ff @(posedge debug_serial_clock) begin
    if (!frame_rst_n) begin
      cnt_q   <= 6'd0;
      rx_sh_q <= 36'h0;
    end else begin
      rx_sh_q <= {rx_sh_q[34:0], debug_serial_in};
      cnt_q   <= (cnt_q == 6'd35) ? 6'd0 : cnt_q + 6'd1;
    end
  end

  always_ff @(posedge debug_serial_clock) begin
    tx_s1_q <= sif.tx_tgl;
    tx_s2_q <= tx_s1_q;
    if (!frame_rst_n) begin
      tx_seen_q <= 1'b0;
      tx_sh_q   <= 32'h0;
      debug_serial_out <= 1'b0;
    end else if (tx_s2_q != tx_seen_q) begin
      tx_seen_q        <= tx_s2_q;
      debug_serial_out <= sif.tx_word[31];
      tx_sh_q          <= {sif.tx_word[30:0], 1'b0};
    end else begin
      debug_serial_out <= tx_sh_q[31];
      tx_sh_q          <= {tx_sh_q[30:0], 1'b0};
    end
  end

  always_ff @(posedge debug_serial_clock) begin
    if (!frame_rst_n) begin
      rx_tgl_q  <= 1'b0;
      rx_word_q <= 36'h0;
    end else if (cnt_q == 6'd35) begin
      rx_tgl_q  <= ~rx_tgl_q;
      rx_word_q <= {rx_sh_q[34:0], debug_serial_in};
    end
  end

  assign sif.rx_word = rx_word_q;
  assign sif.rx_tgl  = rx_tgl_q;
endmodule : dbg_serial_link

// ---- test/dbg_host_model.sv ----
// Development system model on the serial debug link
`timescale 1ns/1ns
module dbg_host_model
  import dbg_pkg::*;
(
  output logic      debug_serial_clock,
  output logic      debug_serial_in,
  output logic      link_rst_n,
  input  wire logic debug_serial_out
);
  // ------
  // Link reset, clock idles low between frames
  // ------
  initial begin
    debug_serial_clock = 1'h0;
    debug_serial_in    = 1'h1;
    link_rst_n         = 1'h0;
    #43;
    repeat (3) begin
      #80 debug_serial_clock = 1'h1;
      #80 debug_serial_clock = 1'h0;
    end
    link_rst_n = 1'h1;
  end

  task automatic xfer(input logic [3:0] cmd, input logic [31:0] dat, output logic [35:0] rx);
    logic [35:0] tx;
    tx = {cmd, dat};
    rx = 36'h0;
    #3;
    for (int i = 35; i >= 0; i--) begin
      debug_serial_in = tx[i];
      #80 debug_serial_clock = 1'h1;
      #5 rx = {rx[34:0], debug_serial_out};
      #75 debug_serial_clock = 1'h0;
    end
    debug_serial_in = ~tx[0];
    #400;
  endtask : xfer
endmodule : dbg_host_model

// ---- test/dbg_csr_checker.sv ----
// Concurrent checks on the debug configuration and status block
`timescale 1ns/1ns
module dbg_csr_checker
  import dbg_pkg::*;
(
  input wire logic        clk,
  input wire logic        rst_n,
  input wire logic        debug_serial_clock,
  input wire logic        debug_serial_out,
  input wire logic        sup_wr,
  input wire logic [31:0] sup_wdata,
  input wire logic        tdr_wr,
  input wire logic        bp_state_upd,
  input wire logic        fault_halt,
  input wire logic        trigger_halt,
  input wire logic        halt_insn,
  input wire logic        breakpoint_request_input,
  input wire logic        core_restart,
  input wire logic        trace_exc,
  input wire logic        in_emulator,
  input wire logic        is_code_ref,
  input wire logic [2:0]  core_irq_priority_level,
  input wire logic [1:0]  transfer_type,
  input wire logic [2:0]  transfer_modifier,
  input wire logic        enter_emulation,
  input wire logic [2:0]  irq_level_eff,
  input wire logic [3:0]  debug_data_port,
  input wire logic [31:0] csr_q
);
  // ------
  // Properties
  // ------
  default clocking cb @(posedge clk);
  endclocking
  default disable iff (!rst_n);

  property p_rst_zero;
    $rose(rst_n) |-> csr_q == CSR_RESET && debug_data_port == 4'h0;
  endproperty
  a_rst_zero: assert property (p_rst_zero) else $error("not clear after reset");
  property p_sup_wr;
    sup_wr && !csr_q[IPW_BIT] |=> csr_q[16:0] == {1'h0, $past(sup_wdata[15:0]) & CFG_WMASK[15:0]};
  endproperty
  a_sup_wr: assert property (p_sup_wr) else $error("write lost");
  property p_ipw;
    sup_wr && csr_q[IPW_BIT] |=> $stable(csr_q[16:0]);
  endproperty
  a_ipw: assert property (p_ipw) else $error("inhibited write landed");
  property p_fof;
    fault_halt |=> csr_q[FOF_BIT];
  endproperty
  a_fof: assert property (p_fof) else $error("fault flag not set");
  property p_restart;
    core_restart && !trigger_halt && !halt_insn && !breakpoint_request_input |=> csr_q[26:24] == 3'h0;
  endproperty
  a_restart: assert property (p_restart) else $error("restart left flags");
  property p_tdr;
    tdr_wr && !bp_state_upd |=> csr_q[31:28] == BP_NONE;
  endproperty
  a_tdr: assert property (p_tdr) else $error("state kept after trigger write");
  property p_map;
    in_emulator |-> transfer_type == (csr_q[MAP_BIT] ? TT_EMU : TT_NORM)
      && transfer_modifier == (is_code_ref ? TM_EMU_CODE : TM_EMU_DATA);
  endproperty
  a_map: assert property (p_map) else $error("emulator mapping wrong");
  property p_irq;
    irq_level_eff == (csr_q[SSM_BIT] && csr_q[IPI_BIT] ? 3'h0 : core_irq_priority_level);
  endproperty
  a_irq: assert property (p_irq) else $error("irq level wrong");
  property p_trace;
    trace_exc && csr_q[TRC_BIT] |-> enter_emulation;
  endproperty
  a_trace: assert property (p_trace) else $error("trace did not force emulation");
  property p_dso;
    $changed(debug_serial_out) |-> $rose(debug_serial_clock);
  endproperty
  a_dso: assert property (p_dso) else $error("serial out moved off edge");
endmodule : dbg_csr_checker

bind debug_config_status_reg dbg_csr_checker u_checker (.*);

// ---- test/testbench.sv ----
// Self-checking bench for the debug configuration and status block
`timescale 1ns/1ns
module testbench
  import dbg_pkg::*;
;
  localparam logic [31:0] LMASK = CFG_WMASK | 32'h00010000;
  logic        clk = 1'h0, rst_n = 1'h0, reset_input = 1'h0;
  logic [11:0] evt = 12'h0;
  logic [31:0] sup_wdata = 32'h0, op_data = 32'h0, br_target = 32'h0, m = 32'h0, d;
  logic [3:0]  bp_state_in = 4'h0, debug_data_port;
  logic [1:0]  op_size = 2'h0, transfer_type;
  logic        op_write = 1'h0, br_variable = 1'h0, user_mode = 1'h0, is_code_ref = 1'h0;
  logic        in_emulator = 1'h0, trace_exc = 1'h0;
  logic [2:0]  core_irq_priority_level = 3'h0, transfer_modifier, irq_level_eff;
  logic        sup_wr, tdr_wr, bp_state_upd, fault_halt, trigger_halt, halt_insn;
  logic        breakpoint_request_input, core_restart, insn_retire, go_cmd, op_valid;
  logic        br_taken, debug_serial_clock, link_rst_n, debug_serial_in, debug_serial_out;
  logic        enter_emulation, halt_allowed, nonpipelined_exec, step_halt;
  logic [31:0] csr_q;
  logic [3:0]  bps [5] = '{BP_NONE, BP_WAIT1, BP_TRIG1, BP_WAIT2, BP_TRIG2};
  int          fails = 0, samples_checked = 0, seed = 32'hcae2922e;

  assign {sup_wr, tdr_wr, bp_state_upd, fault_halt, trigger_halt, halt_insn,
          breakpoint_request_input, core_restart, insn_retire, go_cmd, op_valid, br_taken} = evt;

  debug_config_status_reg u_dut (.*);
  dbg_host_model u_host (.*);

  always #5 clk = ~clk;
  always @(posedge clk)
    {user_mode, is_code_ref, in_emulator, trace_exc, core_irq_priority_level} <= 7'($random(seed));

  // ------
  // Tasks
  // ------
  task automatic check(input string what, input logic [31:0] seen, input logic [31:0] exp);
    samples_checked++;
    if (seen !== exp) begin
      fails++;
      $display("mismatch %s expected %h seen %h", what, exp, seen);
    end
  endtask : check

  task automatic give_verdict;
    $display("checks %0d mismatches %0d", samples_checked, fails);
    if (fails == 0 && samples_checked > 0)
      $display("TB: PASS");
    else
      $display("TB: FAIL");
    $finish;
  endtask : give_verdict

  task automatic pulse(input logic [11:0] v);
    @(posedge clk);
    evt <= v;
    @(posedge clk);
    evt <= 12'h0;
  endtask : pulse

  task automatic sup(input logic [31:0] v);
    sup_wdata <= v;
    pulse(12'h800);
    if (!m[IPW_BIT]) m[15:0] = v[15:0] & CFG_WMASK[15:0];
    #1 check("supervisor write", csr_q, m);
  endtask : sup

  task automatic link(input logic [31:0] v);
    logic [35:0] rx;
    u_host.xfer(CMD_WR_CSR, v, rx);
    m = (m & ~LMASK) | (v & LMASK);
    @(posedge clk);
    #1 check("link write", csr_q, m);
  endtask : link

  task automatic rd_link;
    logic [35:0] rx;
    logic [31:0] e;
    logic        hit;
    e = m;
    u_host.xfer(CMD_RD_CSR, 32'h0, rx);
    m[27:24] = 4'h0;
    u_host.xfer(4'h0, 32'h0, rx);
    hit = 1'h0;
    for (int s = 0; s < 5; s++)
      if (rx[s +: 32] === e && (rx >> (s + 32)) === 36'h0) hit = 1'h1;
    check("serial read", 32'(hit), 32'h1);
  endtask : rd_link

  task automatic watch(input logic [31:0] e, input string what);
    logic [31:0] g;
    int          k;
    g = 32'h0;
    k = -1;
    repeat (14) begin
      #1;
      if (k < 0 && debug_data_port !== 4'h0) k = 0;
      if (k >= 0 && k < 8) begin
        g[4*k +: 4] = debug_data_port;
        k++;
      end
      @(posedge clk);
    end
    check(what, g, e);
  endtask : watch

  // ------
  // Scenarios
  // ------
  initial begin
    repeat (20) @(posedge clk);
    rst_n <= 1'h1;
    @(posedge clk);
    #1 check("reset value", csr_q, m);
    sup(32'h1 << EMU_BIT);
    @(posedge clk);
    reset_input <= 1'h1;
    d = 32'h0;
    repeat (8) begin
      @(posedge clk);
      #1 d += 32'(enter_emulation);
    end
    check("emulation start", d, 32'h1);
    repeat (50) @(posedge clk);
    d = ($random(seed) & LMASK) | 32'h00010000;
    link(d);
    sup(~d & LMASK);
    rd_link;
    link(32'h0);
    foreach (bps[i]) begin
      bp_state_in <= bps[i];
      pulse(12'h200);
      m[31:28] = bps[i];
      repeat (2) @(posedge clk);
      #1 check("state", csr_q, m);
      check("state port", 32'(debug_data_port), 32'({bps[i][3:1], 1'h0}));
    end
    pulse(12'h400);
    m[31:28] = BP_NONE;
    #1 check("trigger write", csr_q, m);
    pulse(12'h1e0);
    m[27:24] = 4'hf;
    #1 check("flags set", csr_q, m);
    pulse(12'h010);
    m[26:24] = 3'h0;
    #1 check("restart", csr_q, m);
    pulse(12'h0e0);
    m[26:24] = 3'h7;
    rd_link;
    @(posedge clk);
    #1 check("flags after read", csr_q, m);
    sup(32'h1 << SSM_BIT);
    pulse(12'h008);
    #1 check("step halt", 32'(step_halt), 32'h1);
    pulse(12'h004);
    #1 check("resume", 32'(step_halt), 32'h0);
    for (int c = 0; c < 4; c++)
      for (int w = 0; w < 2; w++) begin
        sup(32'(c) << DDC_LSB);
        d = $random(seed) | 32'h11111111;
        op_write <= w[0];
        op_size <= SZ_LONG;
        op_data <= d;
        pulse(12'h002);
        watch((c[0] && w[0]) || (c[1] && !w[0]) ? d : 32'h0, "operand");
      end
    for (int s = 0; s < 3; s++) begin
      d = $random(seed) | 32'h11111111;
      op_size <= s == 0 ? SZ_BYTE : s == 1 ? SZ_WORD : SZ_LONG;
      op_data <= d;
      pulse(12'h002);
      watch(d & ~(32'hffffffff << (8 << s)), "operand width");
    end
    for (int b = 0; b < 4; b++)
      for (int v = 0; v < 2; v++) begin
        sup(32'(b) << BTB_LSB);
        d = $random(seed) | 32'h11111111;
        br_variable <= v[0];
        br_target <= d;
        pulse(12'h001);
        watch(v && b > 0 ? d & ~(32'hffffffff << (8 * b + 8)) : 32'h0, "branch");
      end
    for (int p = 0; p < 2; p++) begin
      sup(p ? 32'h0000c470 : 32'h00000010);
      repeat (8) begin
        @(posedge clk);
        #1 check("halt allowed", 32'(halt_allowed), 32'(p || !user_mode));
        check("nonpipelined", 32'(nonpipelined_exec), 32'(p));
        check("irq level", 32'(irq_level_eff), 32'(p ? 3'h0 : core_irq_priority_level));
        check("trace emulation", 32'(enter_emulation), 32'(p && trace_exc));
        if (in_emulator) begin
          check("transfer type", 32'(transfer_type), 32'(p ? TT_EMU : TT_NORM));
          check("modifier", 32'(transfer_modifier), 32'(is_code_ref ? 3'h6 : 3'h5));
        end
      end
    end
    give_verdict;
  end

  initial begin
    #200000;
    fails++;
    give_verdict;
  end
endmodule : testbench
